// ===== src/synth_ctrl_cfg.svh
// Constants for the synthesizer control latch logic
// Function
// - Select bits 1,0 load the shifted word into the operating control latch.
// - Counter reset bit high holds reference and N counters in reset.
// - Clearing counter reset restarts N counter aligned to reference counter.
// - Chip enable pin low forces power-down at once regardless of bits.
// - Power-down bit with sync select 0 powers down immediately on latching.
// - Power-down bit with sync select 1 waits for next charge pump event.
// - Any power-down loads counters, three-states pump, resets detect, disables buffer.
// - Serial input register keeps loading words during power-down.
// - Bit 9 of operating latch enables quick settle.
// - Bit 10 picks manual mode 1 (0) or timed mode 2 (1).
// - Mode 1: boost bit from N word switches pump to setting 2, clears back.
// - Mode 2: timeout from bits 14..11 expires, boost self-clears to normal.
// - Timeout counter runs only in timed mode 2.
// - Setting 1 from low field, setting 2 from upper field while boosted.
// - Three-state bit high puts pump output in high impedance.
// - Select bits 11 load operating latch and pulse an internal counter reset.
// - Startup word with sync power-down also triggers power-down from its pulse.
// - Internal reset pulse also resets timeout counter and three-states pump.
// - First N load after startup word repeats the pulse, later ones do not.
// - Counter reset holds counters and three-states pump without sync power-down.
// - Host shifts 24 bits on rising serial clock; strobe high transfers word.
`ifndef SYNTH_CTRL_CFG_SVH
`define SYNTH_CTRL_CFG_SVH
`define WORD_W        24
`define SEL_OPER      2'h2
`define SEL_START     2'h3
`define SEL_REF       2'h0
`define SEL_NCNT      2'h1
`define BIT_CNT_RST   2
`define BIT_PD_EN     3
`define BIT_PUMP_TRI  8
`define BIT_QS_EN     9
`define BIT_QS_MODE   10
`define FLD_TO_LO     11
`define FLD_TO_HI     14
`define FLD_CPN_LO    15
`define FLD_CPN_HI    17
`define FLD_CPF_LO    18
`define FLD_CPF_HI    20
`define BIT_PD_SYNC   21
`define BIT_NBOOST    21
`define TO_STEP       16'h0003
`endif

// ===== src/synth_ctrl_pkg.sv
// Types for the synthesizer control latch logic
package synth_ctrl_pkg;
	typedef enum logic [1:0] {PWR_ON, PWR_WAIT, PWR_DOWN} pwr_t;
endpackage

// ===== src/synth_control_latch_logic.sv
// Serial control latches, power-down and quick-settle control
`timescale 1ns/1ps
`include "synth_ctrl_cfg.svh"
module synth_control_latch_logic (
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	input  wire logic        sclk_i,
	input  wire logic        sdata_i,
	input  wire logic        load_strobe_i,
	input  wire logic        chip_enable_pin_i,
	input  wire logic        pump_event_i,
	input  wire logic        timeout_tick_i,
	output logic             counter_hold_o,
	output logic             pump_tristate_o,
	output logic             powered_down_o,
	output logic             ref_buf_en_o,
	output logic             clk_detect_rst_o,
	output logic             pump_boost_o,
	output logic [2:0]       pump_current_o,
	output logic             internal_reset_o
);
	// ****************************************
	// Link domain: shift register
	// ****************************************
	logic [`WORD_W-1:0] shift_r;
	logic [`WORD_W-1:0] held_r;
	logic               held_tgl_r;

	// Shift on rising serial clock, keeps running in power-down
	always_ff @(posedge sclk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			shift_r <= '0;
		else
			shift_r <= {shift_r[`WORD_W-2:0], sdata_i};
	end

	// Strobe rise captures word; toggle crosses event to core clock
	always_ff @(posedge load_strobe_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			held_r     <= '0;
			held_tgl_r <= 1'b0;
		end else begin
			held_r     <= shift_r;
			held_tgl_r <= ~held_tgl_r;
		end
	end

	// ****************************************
	// Crossings into the core clock
	// ****************************************
	logic [2:0] tgl_sync_r;
	logic [2:0] ce_sync_r;
	logic [2:0] ev_sync_r;
	logic       tgl_seen_r;
	logic       ce_r;
	logic       ev_prev_r;

	// Three-stage chains; the first stage feeds only the second
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tgl_sync_r <= 3'h0;
			ce_sync_r  <= 3'h0;
			ev_sync_r  <= 3'h0;
		end else begin
			tgl_sync_r <= {tgl_sync_r[1:0], held_tgl_r};
			ce_sync_r  <= {ce_sync_r[1:0], chip_enable_pin_i};
			ev_sync_r  <= {ev_sync_r[1:0], pump_event_i};
		end
	end

	// Accept a change once stages two and three agree
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tgl_seen_r <= 1'b0;
			ce_r       <= 1'b0;
			ev_prev_r  <= 1'b0;
		end else begin
			if (tgl_sync_r[1] == tgl_sync_r[2])
				tgl_seen_r <= tgl_sync_r[2];
			if (ce_sync_r[1] == ce_sync_r[2])
				ce_r <= ce_sync_r[2];
			if (ev_sync_r[1] == ev_sync_r[2])
				ev_prev_r <= ev_sync_r[2];
		end
	end

	wire ev_stable = (ev_sync_r[1] == ev_sync_r[2]) ? ev_sync_r[2] : ev_prev_r;
	wire pump_ev   = ev_stable & ~ev_prev_r;
	wire tgl_now   = (tgl_sync_r[1] == tgl_sync_r[2]) ? tgl_sync_r[2] : tgl_seen_r;
	// Word is stable in held_r: strobe edge is long past once the toggle settles
	wire word_new  = tgl_now ^ tgl_seen_r;

	// ****************************************
	// Latch decode
	// ****************************************
	wire [1:0] sel      = held_r[1:0];
	wire       ld_oper  = word_new & (sel == `SEL_OPER);
	wire       ld_start = word_new & (sel == `SEL_START);
	wire       ld_ncnt  = word_new & (sel == `SEL_NCNT);

	logic [`WORD_W-1:0] oper_r;
	logic               n_first_r;
	logic               ireset_r;

	// Startup word loads the same contents as the operating word
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			oper_r <= '0;
		else if (ld_oper | ld_start)
			oper_r <= held_r;
	end

	// Arm the repeat pulse for the first N load only
	wire n_first_nxt = ld_start ? 1'b1 : (ld_ncnt ? 1'b0 : n_first_r);
	wire ireset_nxt  = ld_start | (ld_ncnt & n_first_r);

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			n_first_r <= 1'b0;
			ireset_r  <= 1'b0;
		end else begin
			n_first_r <= n_first_nxt;
			ireset_r  <= ireset_nxt;
		end
	end

	// ****************************************
	// Power-down
	// ****************************************
	wire pd_en   = oper_r[`BIT_PD_EN];
	wire pd_sync = oper_r[`BIT_PD_SYNC];
	synth_ctrl_pkg::pwr_t pwr_r, pwr_nxt;

	// Pin wins; async on latch; sync waits for pump event or startup pulse
	always_comb begin
		pwr_nxt = pwr_r;
		case (pwr_r)
			synth_ctrl_pkg::PWR_ON:
				if (pd_en & ~pd_sync)
					pwr_nxt = synth_ctrl_pkg::PWR_DOWN;
				else if (pd_en & pd_sync & ireset_r)
					pwr_nxt = synth_ctrl_pkg::PWR_DOWN;
				else if (pd_en & pd_sync)
					pwr_nxt = synth_ctrl_pkg::PWR_WAIT;
			synth_ctrl_pkg::PWR_WAIT:
				if (~pd_en)
					pwr_nxt = synth_ctrl_pkg::PWR_ON;
				else if (~pd_sync)
					pwr_nxt = synth_ctrl_pkg::PWR_DOWN;
				else if (pump_ev | ireset_r)
					pwr_nxt = synth_ctrl_pkg::PWR_DOWN;
			synth_ctrl_pkg::PWR_DOWN:
				if (~pd_en)
					pwr_nxt = synth_ctrl_pkg::PWR_ON;
			default:
				pwr_nxt = synth_ctrl_pkg::PWR_ON;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			pwr_r <= synth_ctrl_pkg::PWR_ON;
		else
			pwr_r <= pwr_nxt;
	end

	wire pd_any = ~ce_r | (pwr_r == synth_ctrl_pkg::PWR_DOWN);
	// Counter reset holds without touching the power-down state
	wire hold_any = pd_any | oper_r[`BIT_CNT_RST] | ireset_r;

	// ****************************************
	// Quick settle
	// ****************************************
	logic       boost_r;
	logic [3:0] to_cnt_r;
	wire qs_en    = oper_r[`BIT_QS_EN];
	wire qs_timed = oper_r[`BIT_QS_MODE];
	wire [3:0] to_sel = oper_r[`FLD_TO_HI:`FLD_TO_LO];
	wire to_run   = qs_en & qs_timed & boost_r & ~hold_any;
	wire to_done  = to_run & timeout_tick_i & (to_cnt_r == to_sel);

	// N word sets or clears boost; timed mode clears it on expiry
	wire boost_nxt = (ld_ncnt & qs_en) ? held_r[`BIT_NBOOST] :
	                 (to_done ? 1'b0 : boost_r);
	wire [3:0] to_nxt = (hold_any | ~to_run | ld_ncnt) ? 4'h0 :
	                    (timeout_tick_i ? to_cnt_r + 4'h1 : to_cnt_r);

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			boost_r  <= 1'b0;
			to_cnt_r <= 4'h0;
		end else begin
			boost_r  <= boost_nxt;
			to_cnt_r <= to_nxt;
		end
	end

	wire [2:0] cur_nxt = (boost_r & qs_en) ? oper_r[`FLD_CPF_HI:`FLD_CPF_LO] :
	                     oper_r[`FLD_CPN_HI:`FLD_CPN_LO];

	// ****************************************
	// Registered outputs
	// ****************************************
	// Counter release aligns both counters as the hold drops together
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			counter_hold_o   <= 1'b1;
			pump_tristate_o  <= 1'b1;
			powered_down_o   <= 1'b1;
			ref_buf_en_o     <= 1'b0;
			clk_detect_rst_o <= 1'b1;
			pump_boost_o     <= 1'b0;
			pump_current_o   <= 3'h0;
			internal_reset_o <= 1'b0;
		end else begin
			counter_hold_o   <= hold_any;
			pump_tristate_o  <= hold_any | oper_r[`BIT_PUMP_TRI];
			powered_down_o   <= pd_any;
			ref_buf_en_o     <= ~pd_any;
			clk_detect_rst_o <= pd_any;
			pump_boost_o     <= boost_r & qs_en;
			pump_current_o   <= cur_nxt;
			internal_reset_o <= ireset_r;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	// Operating word lands one cycle after its decode
	AST_SEL_OPER: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		ld_oper |=> oper_r == $past(held_r)) else $error("Operating latch not loaded");

	// Reference words pass by this block untouched
	AST_REF_IGNORED: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		word_new && sel == `SEL_REF |=> oper_r == $past(oper_r)) else $error("Reference word changed latch");

	// Counter reset bit keeps the counters held
	AST_CNT_RST: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		oper_r[`BIT_CNT_RST] |=> counter_hold_o) else $error("Counter reset not held");

	// Both counters share one hold, so release is aligned
	AST_RELEASE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!hold_any |=> !counter_hold_o) else $error("Counters not released together");

	// Pin low outranks the programmed bits
	AST_CE_LOW: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!ce_r |=> powered_down_o && pump_tristate_o) else $error("Pin power-down missed");

	// Async mode: down two cycles after the bits are seen
	AST_ASYNC_PD: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		pd_en && !pd_sync |=> ##1 powered_down_o) else $error("Async power-down late");

	// Sync mode must not drop without an event
	AST_SYNC_WAIT: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		pwr_r == synth_ctrl_pkg::PWR_WAIT && pd_sync && pd_en && !pump_ev && !ireset_r
		|=> pwr_r != synth_ctrl_pkg::PWR_DOWN) else $error("Sync power-down early");

	// Sync mode drops on the pump event
	AST_SYNC_EVENT: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		pwr_r == synth_ctrl_pkg::PWR_WAIT && pd_en && pd_sync && pump_ev
		|=> pwr_r == synth_ctrl_pkg::PWR_DOWN) else $error("Sync power-down missed event");

	// Every power-down source has the same effects
	AST_PD_EFFECT: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		pd_any |=> counter_hold_o && !ref_buf_en_o && clk_detect_rst_o) else $error("Power-down effects");

	// Timeout counter sits at load state in power-down
	AST_PD_LOAD: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		pd_any |=> to_cnt_r == 4'h0 && pump_tristate_o) else $error("Timeout counter not loaded");

	// No boost without quick settle
	AST_QS_OFF: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!qs_en |=> !pump_boost_o) else $error("Boost without quick settle");

	// Manual mode keeps boost until the next N word
	AST_MODE1_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		qs_en && !qs_timed && boost_r && !ld_ncnt |=> boost_r) else $error("Manual boost dropped");

	// N word sets or clears boost
	AST_BOOST_SET: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		ld_ncnt && qs_en |=> boost_r == $past(held_r[`BIT_NBOOST])) else $error("Boost not taken from N word");

	// Timeout counter steps once per tick
	AST_TO_COUNT: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		to_run && timeout_tick_i && !to_done && !ld_ncnt |=> to_cnt_r == $past(to_cnt_r) + 4'h1)
		else $error("Timeout counter did not step");

	// Expiry clears boost
	AST_TO_CLEAR: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		to_done && !ld_ncnt |=> !boost_r) else $error("Boost not cleared on timeout");

	// Counter only runs in timed mode
	AST_TO_IDLE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!qs_timed |=> to_cnt_r == 4'h0) else $error("Timeout ran outside timed mode");

	// Normal current when quick settle is off
	AST_CURRENT: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!qs_en |=> pump_current_o == $past(oper_r[`FLD_CPN_HI:`FLD_CPN_LO])) else $error("Wrong current");

	// Fast current while boosted
	AST_BOOST_CUR: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		boost_r && qs_en |=> pump_current_o == $past(oper_r[`FLD_CPF_HI:`FLD_CPF_LO])) else $error("Wrong fast current");

	// Three-state bit forces high impedance
	AST_TRI: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		oper_r[`BIT_PUMP_TRI] |=> pump_tristate_o) else $error("Pump not three-stated");

	// Pump driven when nothing asks for three-state
	AST_TRI_OFF: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!oper_r[`BIT_PUMP_TRI] && !hold_any |=> !pump_tristate_o) else $error("Pump three-stated needlessly");

	// Startup word pulses two cycles after decode
	AST_START_PULSE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		ld_start |=> ##1 internal_reset_o) else $error("No startup pulse");

	// Startup word loads the operating contents
	AST_START_LOAD: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		ld_start |=> oper_r == $past(held_r)) else $error("Startup word not loaded");

	// Pulse lasts one cycle only
	AST_PULSE_ONE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		internal_reset_o |=> !internal_reset_o) else $error("Internal pulse too long");

	// Pulse completes a programmed sync power-down
	AST_START_SYNC_PD: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		ireset_r && pd_en && pd_sync |=> pwr_r == synth_ctrl_pkg::PWR_DOWN) else $error("Pulse missed sync power-down");

	// Pulse loads counters and three-states the pump
	AST_PULSE_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		ireset_r |=> counter_hold_o && pump_tristate_o && to_cnt_r == 4'h0) else $error("Pulse did not load counters");

	// Later N loads stay quiet
	AST_N_REPEAT: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		ld_ncnt && !n_first_r |=> !ireset_r) else $error("Extra pulse on N load");

	// Counter reset holds without powering down
	AST_CNT_RST_NO_PD: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		oper_r[`BIT_CNT_RST] && ce_r && pwr_r == synth_ctrl_pkg::PWR_ON |=> counter_hold_o && !powered_down_o)
		else $error("Counter reset powered down");

	// One decode per strobe, however long the toggle settles
	AST_WORD_ONE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		word_new |=> !word_new) else $error("Word decoded twice");

	// Main scenarios
	COV_START: cover property (@(posedge mclk_i) disable iff (!rst_b_i) ld_start ##[1:200] ld_ncnt);
	COV_SYNC_PD: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
		pwr_r == synth_ctrl_pkg::PWR_WAIT ##1 pwr_r == synth_ctrl_pkg::PWR_DOWN);
	COV_TIMEOUT: cover property (@(posedge mclk_i) disable iff (!rst_b_i) to_done);
	COV_BOOST: cover property (@(posedge mclk_i) disable iff (!rst_b_i) ld_ncnt && qs_en && held_r[`BIT_NBOOST]);
	COV_PIN_DOWN: cover property (@(posedge mclk_i) disable iff (!rst_b_i) !ce_r && pwr_r == synth_ctrl_pkg::PWR_ON);
endmodule // synth_control_latch_logic

// ===== test/synth_host_model.sv
// Host model driving the three-wire serial link
`timescale 1ns/1ps
module synth_host_model (
	output logic sclk_o,
	output logic sdata_o,
	output logic load_strobe_o
);
	// Link clock stands low between frames
	initial begin
		sclk_o = 1'b0;
		sdata_o = 1'b0;
		load_strobe_o = 1'b0;
	end
	// One 24-bit word, first bit DB23, then strobe high
	task automatic send(input logic [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			sdata_o = w[i];
			#8 sclk_o = 1'b1;
			#16 sclk_o = 1'b0;
			#8;
		end
		sdata_o = ~w[0]; // Released line must not look held
		load_strobe_o = 1'b1;
		#64 load_strobe_o = 1'b0;
	endtask
endmodule // synth_host_model

// ===== test/synth_control_latch_logic_tb_top.sv
// Self-checking bench for the synthesizer control latch logic
`timescale 1ns/1ps
module synth_control_latch_logic_tb_top;
	// Row: serial word beside the output state it should give
	typedef struct {logic [23:0] w; logic [8:0] e;} row_t;
	logic       mclk;
	logic       rst_b = 1'b1;
	logic       ce = 1'b1;
	logic       pev = 1'b0;
	logic       tick = 1'b0;
	logic       sclk, sdata, strobe, hold, tri_s, pd, rbuf, cdr, boost, irst;
	logic [2:0] cur;
	logic [8:0] st;
	int         num_errors = 0;
	int         n_compared = 0;
	int         npulse = 0;
	int         pulse_base = 0;
	row_t       rows [5] = '{'{24'h000002, 9'h020}, '{24'h000006, 9'h0E0}, '{24'h000102, 9'h060},
		'{24'h0E8002, 9'h025}, '{24'h00000A, 9'h1D0}};

	// Packed view: down, hold, three-state, buffer, detect reset, boost, current
	assign st = {pd, hold, tri_s, rbuf, cdr, boost, cur};

	synth_host_model u_host (.sclk_o(sclk), .sdata_o(sdata), .load_strobe_o(strobe));
	synth_control_latch_logic u_dut (.mclk_i(mclk), .rst_b_i(rst_b), .sclk_i(sclk), .sdata_i(sdata),
		.load_strobe_i(strobe), .chip_enable_pin_i(ce), .pump_event_i(pev), .timeout_tick_i(tick),
		.counter_hold_o(hold), .pump_tristate_o(tri_s), .powered_down_o(pd), .ref_buf_en_o(rbuf),
		.clk_detect_rst_o(cdr), .pump_boost_o(boost), .pump_current_o(cur), .internal_reset_o(irst));

	// Core clock, 20 ns
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// Pulse counter; the pulse lasts one cycle so it is easy to miss by eye
	always @(posedge mclk) begin
		if (irst === 1'b1) begin
			npulse <= npulse + 1;
		end
	end

	// ****************
	// Shared tasks
	// ****************
	task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] s);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Inputs change 2 ns after the edge, never on it
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	// Word crossing takes about 6 cycles; 10 leaves margin
	task automatic put(input logic [23:0] w);
		u_host.send(w);
		cyc(10);
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			tick = 1'b1;
			cyc(1);
			tick = 1'b0;
			cyc(1);
		end
	endtask
	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ****************
	// Main sequence
	// ****************
	initial begin
		// A real falling edge, so strobe-clocked flops reset too
		#2;
		rst_b = 1'b0;
		cyc(10);
		chk("reset state", 9'h1D0, st);
		cyc(2);
		rst_b = 1'b1;
		foreach (rows[i]) begin
			put(rows[i].w);
			chk("row state", rows[i].e, st);
		end
		$display("test rows done");
		put(24'h000002);
		ce = 1'b0;
		cyc(10);
		chk("pin down", 9'h1D0, st);
		put(24'h0E8002);
		ce = 1'b1;
		cyc(10);
		chk("word taken while down", 9'h025, st);
		$display("test chip enable done");
		put(24'h20000A);
		chk("sync pending", 9'h020, st);
		pev = 1'b1;
		cyc(10);
		chk("sync down", 9'h1D0, st);
		pev = 1'b0;
		$display("test sync down done");
		put(24'h188202);
		chk("mode1 idle", 9'h021, st);
		put(24'h200001);
		chk("mode1 boost", 9'h02E, st);
		ticks(20);
		chk("mode1 no timeout", 9'h02E, st);
		put(24'h000001);
		chk("mode1 clear", 9'h021, st);
		put(24'h189602);
		put(24'h200001);
		ticks(2);
		chk("mode2 running", 9'h02E, st);
		ticks(1);
		chk("mode2 expired", 9'h021, st);
		$display("test quick settle done");
		pulse_base = npulse;
		put(24'h000003);
		put(24'h000002);
		put(24'h000004);
		chk("reference word ignored", 9'h020, st);
		put(24'h000001);
		put(24'h000001);
		chk("pulse count", 9'h002, 9'(npulse - pulse_base));
		chk("after startup", 9'h020, st);
		put(24'h20000B);
		chk("startup sync down", 9'h1D0, st);
		$display("test startup done");
		rst_b = 1'b0;
		cyc(3);
		chk("second reset", 9'h1D0, st);
		$display("test second reset done");
		summarize();
	end
	// Hang guard
	initial begin
		#1000000;
		num_errors++;
		summarize();
	end
endmodule // synth_control_latch_logic_tb_top
